// file: afmt_regs.svh
`ifndef AFMT_REGS_SVH
`define AFMT_REGS_SVH

// ****************************************************************
// Widths and reset values.
// ****************************************************************
`define AFMT_CODE_W 3
`define AFMT_CODE_RST 3'h0
`define AFMT_PHASE_EVEN 1'b0
`define AFMT_PHASE_ODD 1'b1

`endif

// file: afmt_pkg.sv
`include "afmt_regs.svh"

package afmt_pkg;
  typedef logic [`AFMT_CODE_W-1:0] afmt_code_t;
endpackage

// file: afmt_output_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`include "afmt_regs.svh"

// Functional notes
// RULE1 - Over-range flag goes high when the sample is above top or below bottom tap.
// RULE2 - Over-range flag clears on the next in-range sample; it is never sticky.
// RULE3 - Asserted inhibit forces all core data to zero.
// RULE4 - Inhibit zeroing happens before the modulation stage and the demultiplexer.
// RULE5 - The far side holds inhibit deasserted for normal conversion.
// RULE6 - Modulation applies to all core outputs before the demultiplexer.
// RULE7 - The modulation input is resampled by the full-rate clock before use.
// RULE8 - Retimed modulation low inverts the outputs; high passes them unchanged.
// RULE9 - A square-wave modulation source runs at the clock over a power of two.
// RULE10 - Lane order depends on the modulation sampling phase; either lane may lead.
// RULE11 - The far side tunes a delay to keep modulation edges off clock edges; the model uses fixed edges midway between sample edges instead.
// RULE12 - Inhibit with modulation running yields a known alignment pattern.
// RULE13 - Receiver reads flag high with zero data as code zero.
// RULE14 - Receiver maps flag-low data onto codes one through eight.
// RULE15 - Receiver reads flag high with all data ones as code nine.
// RULE16 - Each lane carries its own differential over-range output beside its data.
// RULE17 - Samples alternate between lanes, with an aligned half-rate clock out.
module afmt_output_formatter (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire afmt_pkg::afmt_code_t core_code_i,
  input wire logic core_above_top_i,
  input wire logic core_below_bottom_i,
  input wire logic inhibit_pos_i,
  input wire logic inhibit_neg_i,
  input wire logic modulation_in_pos_i,
  input wire logic modulation_in_neg_i,
  output afmt_pkg::afmt_code_t lane_a_data_pos_o,
  output afmt_pkg::afmt_code_t lane_a_data_neg_o,
  output logic lane_a_range_pos_o,
  output logic lane_a_range_neg_o,
  output afmt_pkg::afmt_code_t lane_b_data_pos_o,
  output afmt_pkg::afmt_code_t lane_b_data_neg_o,
  output logic lane_b_range_pos_o,
  output logic lane_b_range_neg_o,
  output logic half_rate_clock_out_pos_o,
  output logic half_rate_clock_out_neg_o
);
  import afmt_pkg::*;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic inh_meta_r;
  logic inh_sync_r;
  logic mod_meta_r;
  logic mod_sync_r;
  logic mod_last_r;
  logic inh_raw;
  logic mod_raw;

  // A differential pin counts as high only with the legs apart in the right sense.
  assign inh_raw = inhibit_pos_i & ~inhibit_neg_i;
  assign mod_raw = modulation_in_pos_i & ~modulation_in_neg_i;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      inh_meta_r <= 1'b0;
      inh_sync_r <= 1'b0;
    end else begin
      inh_meta_r <= inh_raw;
      inh_sync_r <= inh_meta_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mod_meta_r <= 1'b1;
      mod_sync_r <= 1'b1;
      mod_last_r <= 1'b1;
    end else begin
      mod_meta_r <= mod_raw;
      mod_sync_r <= mod_meta_r; // RULE7
      mod_last_r <= mod_sync_r;
    end
  end

  // ****************************************************************
  // Core stage: range flag and inhibit.
  // ****************************************************************
  afmt_code_t core_code_r;
  logic core_ovr_r;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      core_code_r <= `AFMT_CODE_RST;
      core_ovr_r <= 1'b0;
    end else if (inh_sync_r) begin
      core_code_r <= `AFMT_CODE_RST; // RULE3 RULE4
      core_ovr_r <= 1'b0;
    end else begin
      core_code_r <= core_code_i;
      // Recomputed every sample, so an in-range sample clears it at once.
      core_ovr_r <= core_above_top_i | core_below_bottom_i; // RULE1 RULE2
    end
  end

  // ****************************************************************
  // Modulation stage, ahead of the demultiplexer.
  // ****************************************************************
  afmt_code_t mix_code_r;
  logic mix_ovr_r;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mix_code_r <= `AFMT_CODE_RST;
      mix_ovr_r <= 1'b0;
    end else begin
      mix_code_r <= core_code_r ^ {`AFMT_CODE_W{~mod_sync_r}}; // RULE6 RULE8
      mix_ovr_r <= core_ovr_r ^ ~mod_sync_r; // RULE6 RULE8 RULE12
    end
  end

  // ****************************************************************
  // Demultiplexer and half-rate clock.
  // ****************************************************************
  logic phase_r;
  afmt_code_t hold_code_r;
  logic hold_ovr_r;
  logic mod_rise;

  assign mod_rise = mod_sync_r & ~mod_last_r;

  // The phase realigns to each retimed modulation rise, so which lane leads depends
  // on the clock edge at which the modulation is caught. Receivers must resolve order.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      phase_r <= `AFMT_PHASE_EVEN;
    end else if (mod_rise) begin
      phase_r <= `AFMT_PHASE_EVEN; // RULE10
    end else begin
      phase_r <= ~phase_r; // RULE17
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hold_code_r <= `AFMT_CODE_RST;
      hold_ovr_r <= 1'b0;
    end else if (phase_r == `AFMT_PHASE_EVEN) begin
      hold_code_r <= mix_code_r;
      hold_ovr_r <= mix_ovr_r;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lane_a_data_pos_o <= `AFMT_CODE_RST;
      lane_a_data_neg_o <= ~`AFMT_CODE_RST;
      lane_a_range_pos_o <= 1'b0;
      lane_a_range_neg_o <= 1'b1;
      lane_b_data_pos_o <= `AFMT_CODE_RST;
      lane_b_data_neg_o <= ~`AFMT_CODE_RST;
      lane_b_range_pos_o <= 1'b0;
      lane_b_range_neg_o <= 1'b1;
    end else if (phase_r == `AFMT_PHASE_ODD) begin
      lane_a_data_pos_o <= hold_code_r; // RULE17
      lane_a_data_neg_o <= ~hold_code_r;
      lane_a_range_pos_o <= hold_ovr_r; // RULE16
      lane_a_range_neg_o <= ~hold_ovr_r;
      lane_b_data_pos_o <= mix_code_r; // RULE17
      lane_b_data_neg_o <= ~mix_code_r;
      lane_b_range_pos_o <= mix_ovr_r; // RULE16
      lane_b_range_neg_o <= ~mix_ovr_r;
    end
  end

  // The clock rises with each lane update, giving one period per sample pair.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      half_rate_clock_out_pos_o <= 1'b0;
      half_rate_clock_out_neg_o <= 1'b1;
    end else begin
      half_rate_clock_out_pos_o <= phase_r; // RULE17
      half_rate_clock_out_neg_o <= ~phase_r;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_out_range;
    !inh_sync_r && (core_above_top_i || core_below_bottom_i);
  endsequence

  sequence s_in_range;
    !inh_sync_r && !core_above_top_i && !core_below_bottom_i;
  endsequence

  a_range_flag_set: assert property (s_out_range |=> core_ovr_r) // RULE1
    else $error("Over-range sample did not raise the flag.");

  a_range_flag_clear: assert property (s_in_range |=> !core_ovr_r) // RULE2
    else $error("In-range sample left the flag set.");

  a_inhibit_zeroes_core: assert property (inh_sync_r |=> (core_code_r == 3'h0) && !core_ovr_r) // RULE3
    else $error("Inhibit did not zero the core data.");

  a_inhibit_before_mix: assert property (inh_sync_r ##1 mod_sync_r |=> mix_code_r == 3'h0) // RULE4
    else $error("Inhibited data reached the modulation stage non-zero.");

  a_mod_retimed: assert property (##2 mod_sync_r == $past(mod_raw, 2)) // RULE7
    else $error("Modulation not retimed by two clock stages.");

  a_mod_invert: assert property (!mod_sync_r |=> mix_code_r == ~$past(core_code_r)) // RULE6 RULE8
    else $error("Low modulation did not invert the data.");

  a_mod_pass: assert property (mod_sync_r |=> mix_ovr_r == $past(core_ovr_r)) // RULE8
    else $error("High modulation altered the range flag.");

  a_lane_realign: assert property (mod_rise |=> phase_r == 1'b0 ##1 phase_r == 1'b1) // RULE10
    else $error("Lane phase did not realign to the modulation edge.");

  a_lane_pair: assert property (phase_r |=> lane_b_data_pos_o == $past(mix_code_r) // RULE17
    && lane_a_data_pos_o == $past(hold_code_r) && half_rate_clock_out_pos_o)
    else $error("Lane pair or half-rate clock misaligned.");

  a_range_diff: assert property (lane_a_range_neg_o == !lane_a_range_pos_o // RULE16
    && lane_b_range_neg_o == !lane_b_range_pos_o)
    else $error("Lane range legs not complementary.");

endmodule

`default_nettype wire

// file: afmt_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Far-side receiver model: drives the control legs, decodes levels.
// ****************************************************************
module afmt_rx_model (
  input wire logic inhibit_req_i,
  input wire logic mod_run_i,
  input wire logic mod_level_i,
  input wire afmt_pkg::afmt_code_t lane_data_i,
  input wire logic lane_range_i,
  output logic inhibit_pos_o,
  output logic inhibit_neg_o,
  output logic modulation_pos_o,
  output logic modulation_neg_o,
  output logic [3:0] level_o
);
  import afmt_pkg::*;
  logic sq_r = 1'b1;
  // Edges sit midway between sample edges so the retiming never sees a race.
  always begin
    #100 sq_r = ~sq_r;
  end
  assign inhibit_pos_o = inhibit_req_i;
  assign inhibit_neg_o = ~inhibit_req_i;
  assign modulation_pos_o = mod_run_i ? sq_r : mod_level_i;
  assign modulation_neg_o = ~modulation_pos_o;
  always_comb begin
    if (lane_range_i) begin
      level_o = (lane_data_i == 3'h7) ? 4'h9 : 4'h0;
    end else begin
      level_o = {1'b0, lane_data_i} + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: afmt_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t %h %h", $time, g, e); end end
// ****************************************************************
// Self-checking bench.
// ****************************************************************
module tb;
  import afmt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  afmt_code_t code = 3'h0;
  logic above = 1'b0;
  logic below = 1'b0;
  logic inh = 1'b0;
  logic run = 1'b0;
  logic lvl = 1'b1;
  logic ip, inn, mp, mn, arp, arn, brp, brn, ckp, ckn;
  afmt_code_t adp, adn, bdp, bdn;
  logic [3:0] level;
  int failures = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  afmt_rx_model afmt_rx_model_inst (.inhibit_req_i(inh), .mod_run_i(run), .mod_level_i(lvl),
    .lane_data_i(adp), .lane_range_i(arp), .inhibit_pos_o(ip), .inhibit_neg_o(inn),
    .modulation_pos_o(mp), .modulation_neg_o(mn), .level_o(level));
  afmt_output_formatter afmt_output_formatter_inst (.core_clk_i(clk), .sys_rst_i(rst),
    .core_code_i(code), .core_above_top_i(above), .core_below_bottom_i(below),
    .inhibit_pos_i(ip), .inhibit_neg_i(inn), .modulation_in_pos_i(mp),
    .modulation_in_neg_i(mn), .lane_a_data_pos_o(adp), .lane_a_data_neg_o(adn),
    .lane_a_range_pos_o(arp), .lane_a_range_neg_o(arn), .lane_b_data_pos_o(bdp),
    .lane_b_data_neg_o(bdn), .lane_b_range_pos_o(brp), .lane_b_range_neg_o(brn),
    .half_rate_clock_out_pos_o(ckp), .half_rate_clock_out_neg_o(ckn));
  task step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task drive(afmt_code_t c, logic a, logic b);
    code = c;
    above = a;
    below = b;
  endtask
  task conclude;
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task t_pass;
    drive(3'h5, 1'b0, 1'b0);
    step(8);
    `CHK({adp, bdp, arp, brp}, 8'hb4)
    `CHK({adn, arn}, 4'h5)
    `CHK({bdn, brn, ckp, ckn}, 6'h15)
    `CHK(level, 4'h6)
  endtask
  task t_order;
    int i;
    for (i = 0; i < 16; i++) begin
      drive(i[2:0], 1'b0, 1'b0);
      step(1);
      if (i > 8 && ckp === 1'b1) `CHK(bdp, adp + 3'h1)
    end
  endtask
  task t_range;
    int k;
    logic seen;
    logic [3:0] want;
    for (k = 0; k < 2; k++) begin
      want = k ? 4'h0 : 4'h9;
      seen = 1'b0;
      drive(k ? 3'h0 : 3'h7, k == 0, k == 1);
      step(2);
      drive(3'h3, 1'b0, 1'b0);
      repeat (6) begin
        step(1);
        if (level === want) seen = 1'b1;
      end
      `CHK(seen, 1'b1)
      `CHK({arp, brp}, 2'b00)
    end
  endtask
  task t_inhibit;
    inh = 1'b1;
    drive(3'h5, 1'b1, 1'b0);
    step(8);
    `CHK({adp, bdp, arp, brp}, 8'h00)
    lvl = 1'b0;
    step(8);
    `CHK({adp, bdp, arp, brp}, 8'hff)
    inh = 1'b0;
    drive(3'h5, 1'b0, 1'b0);
    step(8);
    `CHK({adp, arp}, 4'h5)
    lvl = 1'b1;
  endtask
  task t_sync;
    int n0;
    int n1;
    n0 = 0;
    n1 = 0;
    inh = 1'b1;
    run = 1'b1;
    step(8);
    repeat (48) begin
      step(1);
      if (adp === 3'h0 && arp === 1'b0) n0++;
      else if (adp === 3'h7 && arp === 1'b1) n1++;
    end
    `CHK(n0 + n1, 48)
    `CHK(n0 > 8 && n1 > 8, 1'b1)
    run = 1'b0;
    inh = 1'b0;
  endtask
  // Reset is long enough to flush both pin synchronisers.
  initial begin
    step(8);
    rst = 1'b0;
    step(3);
    t_pass;
    t_order;
    t_range;
    t_inhibit;
    t_sync;
    conclude;
  end
  initial begin
    #10000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
